// File: sars_pkg.sv
/*
  Constants and types shared by the converter readout sequencer.
  Assumes a 40 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package sars_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_MHZ = 40;
  localparam real T_CHAN_US = 63.33;
  localparam int CHAN_CYCLES = $rtoi(T_CHAN_US * CLK_MHZ);
  localparam logic [15:0] CONV_CYCLES = 16'h000C;
  localparam logic [15:0] INTA_CYCLES = 16'h0002;
  localparam logic [15:0] EN_DLY_RST = 16'h0028;
  localparam logic [15:0] SMP_RST =
    16'(CHAN_CYCLES) - CONV_CYCLES - INTA_CYCLES;

  // ********************************************************************
  // Modes, channels and states
  // ********************************************************************
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_RR = 2'h1;
  localparam logic [1:0] MODE_ONCE = 2'h2;
  localparam logic [1:0] MODE_BAD = 2'h3;
  localparam logic [4:0] AUTO_LAST = 5'h0B;
  localparam int NUM_RES = 12;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ENWAIT = 3'h1,
    S_SAMPLE = 3'h3,
    S_CONVERT = 3'h2,
    S_INTR = 3'h6
  } sars_state_t;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EN_DLY = 8'h04;
  localparam logic [7:0] OFF_SMP = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_SINGLE = 8'h18;
  localparam logic [7:0] OFF_RES0 = 8'h20;
  localparam logic [7:0] OFF_RES_END = 8'h50;

  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_EN_DLY = 5'h01;
  localparam logic [4:0] IDX_SMP = 5'h02;
  localparam logic [4:0] IDX_STATUS = 5'h03;
  localparam logic [4:0] IDX_IRQ_STAT = 5'h04;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h05;
  localparam logic [4:0] IDX_SINGLE = 5'h06;
  localparam logic [4:0] IDX_RES0 = 5'h08;
  localparam logic [4:0] IDX_NONE = 5'h1F;

  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_CONT = 3;
  localparam int CTRL_CHAN = 4;
  localparam int CTRL_START = 9;

  localparam int IRQ_CONV = 0;
  localparam int IRQ_SEQ = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// File: sars_top.sv
/*
  Readout sequencer for a successive-approximation converter, with an
  AXI4-Lite register slave, result registers and an interrupt.
  Assumes the analog front end samples while adc_sample_o is high,
  converts while adc_convert_o is high and presents its 10-bit result
  on adc_result_i by the last conversion cycle. All inputs are
  synchronous to clk_i.
*/
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module sars_top
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic adc_enable_o,
  output logic [4:0] adc_chan_o,
  output logic adc_sample_o,
  output logic adc_convert_o,
  input wire logic [9:0] adc_result_i,
  output logic completion_irq_pulse_o,
  output logic irq_o
);
  import sars_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    sars_state_t st;
    logic en;
    logic [1:0] mode;
    logic cont;
    logic [4:0] chan;
    logic [15:0] en_dly;
    logic [15:0] smp;
    logic [15:0] cnt;
    logic [1:0] act_mode;
    logic [4:0] act_chan;
    logic ready;
    logic run;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [9:0] single_res;
    logic [NUM_RES-1:0][9:0] res;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sars_regs_t;

  sars_regs_t q;
  sars_regs_t d;

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  function automatic logic [4:0] sars_dec(input logic [7:0] a);
    logic [7:0] off;
    off = a - OFF_RES0;
    case (a)
      OFF_CTRL: sars_dec = IDX_CTRL;
      OFF_EN_DLY: sars_dec = IDX_EN_DLY;
      OFF_SMP: sars_dec = IDX_SMP;
      OFF_STATUS: sars_dec = IDX_STATUS;
      OFF_IRQ_STAT: sars_dec = IDX_IRQ_STAT;
      OFF_IRQ_MASK: sars_dec = IDX_IRQ_MASK;
      OFF_SINGLE: sars_dec = IDX_SINGLE;
      default:
      begin
        if (a >= OFF_RES0 && a < OFF_RES_END && a[1:0] == 2'h0)
          sars_dec = IDX_RES0 + off[6:2];
        else
          sars_dec = IDX_NONE;
      end
    endcase
  endfunction

  // Result registers are read straight from flops, so a read never
  // waits on or alters the sequencer.
  function automatic logic [31:0] sars_rd(input sars_regs_t r,
                                          input logic [4:0] idx);
    logic [4:0] ri;
    ri = idx - IDX_RES0;
    case (idx)
      IDX_CTRL: sars_rd = {23'h0, r.chan, r.cont, r.mode, r.en};
      IDX_EN_DLY: sars_rd = {16'h0, r.en_dly};
      IDX_SMP: sars_rd = {16'h0, r.smp};
      IDX_STATUS: sars_rd = {22'h0, r.ready, r.act_chan, r.run, r.st};
      IDX_IRQ_STAT: sars_rd = {30'h0, r.irq_stat};
      IDX_IRQ_MASK: sars_rd = {30'h0, r.irq_mask};
      IDX_SINGLE: sars_rd = {22'h0, r.single_res};
      default:
      begin
        if (idx >= IDX_RES0 && ri < 5'(NUM_RES))
          sars_rd = {22'h0, r.res[ri[3:0]]};
        else
          sars_rd = 32'h0;
      end
    endcase
  endfunction

  function automatic logic [31:0] sars_merge(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        m[i*8 +: 8] = n[i*8 +: 8];
    end
    sars_merge = m;
  endfunction

  // ********************************************************************
  // Next state
  // ********************************************************************
  logic [4:0] widx;
  logic [31:0] wv;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic stop;

  assign s_axi_awready_o = !q.aw_hold && !q.bvalid;
  assign s_axi_wready_o = !q.w_hold && !q.bvalid;
  assign s_axi_arready_o = !q.rvalid;

  always_comb
  begin
    d = q;
    irq_set = 2'h0;
    irq_clr = 2'h0;
    stop = 1'b0;
    widx = sars_dec(q.aw_addr);
    wv = sars_merge(sars_rd(q, widx), q.w_data, q.w_strb);

    // Write channel: address and data are held until both are present.
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      d.aw_hold = 1'b1;
      d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      d.w_hold = 1'b1;
      d.w_data = s_axi_wdata_i;
      d.w_strb = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i)
      d.bvalid = 1'b0;
    if (q.aw_hold && q.w_hold)
    begin
      d.aw_hold = 1'b0;
      d.w_hold = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (widx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
      case (widx)
        IDX_CTRL:
        begin
          // Only the live copies change here; the sequencer picks up mode, chan
          // and cont at the next conversion boundary, but a cleared en acts at once.
          d.en = wv[CTRL_EN];
          if (wv[CTRL_MODE +: 2] != MODE_BAD)
            d.mode = wv[CTRL_MODE +: 2];
          d.cont = wv[CTRL_CONT];
          d.chan = wv[CTRL_CHAN +: 5];
          if (wv[CTRL_START] && wv[CTRL_EN] && q.st == S_IDLE)
            d.run = 1'b1;
        end
        IDX_EN_DLY: d.en_dly = wv[15:0];
        IDX_SMP: d.smp = wv[15:0];
        IDX_IRQ_STAT: irq_clr = q.w_data[1:0] & {2{q.w_strb[0]}};
        IDX_IRQ_MASK: d.irq_mask = wv[1:0];
        default: ;
      endcase
    end

    // Read channel: one cycle from address to data.
    if (q.rvalid && s_axi_rready_i)
      d.rvalid = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      d.rvalid = 1'b1;
      d.rdata = sars_rd(q, sars_dec(s_axi_araddr_i));
      d.rresp = (sars_dec(s_axi_araddr_i) == IDX_NONE) ?
                RESP_SLVERR : RESP_OKAY;
    end

    // Sequencer.
    case (q.st)
      S_IDLE:
      begin
        if (q.en && q.run)
        begin
          d.act_mode = q.mode;
          d.act_chan = (q.mode == MODE_SINGLE) ? q.chan : 5'h0;
          d.cnt = 16'h1;
          d.st = q.ready ? S_SAMPLE : S_ENWAIT;
        end
      end
      S_ENWAIT:
      begin
        if (q.cnt >= q.en_dly)
        begin
          d.ready = 1'b1;
          d.cnt = 16'h1;
          d.st = S_SAMPLE;
        end
        else
          d.cnt = 16'(q.cnt + 16'h1);
      end
      S_SAMPLE:
      begin
        if (q.cnt >= q.smp)
        begin
          d.cnt = 16'h1;
          d.st = S_CONVERT;
        end
        else
          d.cnt = 16'(q.cnt + 16'h1);
      end
      S_CONVERT:
      begin
        if (q.cnt >= CONV_CYCLES)
        begin
          d.single_res = adc_result_i;
          if (q.act_mode == MODE_SINGLE)
            irq_set[IRQ_CONV] = 1'b1;
          else
            d.res[q.act_chan[3:0]] = adc_result_i;
          d.cnt = 16'h1;
          d.st = S_INTR;
        end
        else
          d.cnt = 16'(q.cnt + 16'h1);
      end
      S_INTR:
      begin
        if (q.cnt >= INTA_CYCLES)
        begin
          if (q.act_mode == MODE_ONCE && q.act_chan == AUTO_LAST)
          begin
            irq_set[IRQ_SEQ] = 1'b1;
            stop = 1'b1;
          end
          if (q.mode == MODE_SINGLE && !q.cont)
            stop = 1'b1;
          d.cnt = 16'h1;
          if (stop)
          begin
            d.run = 1'b0;
            d.st = S_IDLE;
          end
          else
          begin
            // New settings are taken here, between conversions, and in S_IDLE when a run starts.
            d.act_mode = q.mode;
            if (q.mode == MODE_SINGLE)
              d.act_chan = q.chan;
            else if (q.act_mode != MODE_SINGLE && q.act_chan < AUTO_LAST)
              d.act_chan = 5'(q.act_chan + 5'h1);
            else
              d.act_chan = 5'h0;
            d.st = S_SAMPLE;
          end
        end
        else
          d.cnt = 16'(q.cnt + 16'h1);
      end
      default: d.st = S_IDLE;
    endcase

    // Disabling aborts at the same edge that clears the enable, so the
    // front end never sees a phase while it is switched off.
    if (!d.en)
    begin
      d.st = S_IDLE;
      d.ready = 1'b0;
      d.run = 1'b0;
      d.cnt = 16'h0;
    end

    // A hardware set in the same cycle as a clear wins.
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.en_dly <= EN_DLY_RST;
      q.smp <= SMP_RST;
    end
    else
      q <= d;
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  assign adc_enable_o = q.en;
  assign adc_chan_o = q.act_chan;
  assign adc_sample_o = (q.st == S_SAMPLE);
  assign adc_convert_o = (q.st == S_CONVERT);
  assign completion_irq_pulse_o = (q.st == S_INTR);
  assign irq_o = |(q.irq_stat & q.irq_mask);

endmodule // sars_top

`default_nettype wire

// File: sars_adc_model.sv
/*
  Behavioural model of the analog converter front end.
  Assumes the sequencer reads the result on the last conversion cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module sars_adc_model
(
  input wire logic [4:0] adc_chan_i,
  input wire logic adc_convert_i,
  input wire logic [4:0] salt_i,
  output logic [9:0] adc_result_o
);
  logic [9:0] val;

  // ******************************************************************
  // Result
  // ******************************************************************
  // One sample per conversion, no averaging.
  assign val = {salt_i, adc_chan_i};
  // Outside conversion the bus shows the inverse, so stale reads show.
  assign adc_result_o = adc_convert_i ? val : ~val;
endmodule // sars_adc_model

`default_nettype wire

// File: sars_monitor.sv
/*
  Pin-level checks of the readout sequencer.
  Assumes it is bound to sars_top and runs on its core clock.
*/
`timescale 1ns/100ps
`default_nettype none

module sars_monitor
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic adc_enable_o,
  input wire logic [4:0] adc_chan_o,
  input wire logic adc_sample_o,
  input wire logic adc_convert_o,
  input wire logic completion_irq_pulse_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // ******************************************************************
  // Assertions
  // ******************************************************************
  property p_conv_len;
    $rose(adc_convert_o) |-> adc_convert_o[*8] ##1 adc_convert_o[*4]
      ##1 !adc_convert_o;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");
  property p_pulse;
    $fell(adc_convert_o) && adc_enable_o |->
      completion_irq_pulse_o[*2] ##1 !completion_irq_pulse_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("completion pulse wrong");
  property p_pulse_cause;
    $rose(completion_irq_pulse_o) |-> $past(adc_convert_o);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("pulse without conversion");
  property p_smp_first;
    $rose(adc_convert_o) |-> $past(adc_sample_o);
  endproperty
  a_smp_first: assert property (p_smp_first)
    else $error("conversion without sampling");
  property p_chan_hold;
    adc_convert_o ##1 adc_convert_o |-> $stable(adc_chan_o);
  endproperty
  a_chan_hold: assert property (p_chan_hold)
    else $error("channel moved in conversion");
  property p_off;
    !adc_enable_o |-> !adc_sample_o && !adc_convert_o;
  endproperty
  a_off: assert property (p_off)
    else $error("activity while disabled");
  property p_w_block;
    $rose(s_axi_bvalid_o) |-> $past(!s_axi_awready_o)
      && $past(!s_axi_wready_o);
  endproperty
  a_w_block: assert property (p_w_block)
    else $error("write response before both halves were taken");
  property p_r_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o
      && !s_axi_arready_o;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read not answered next cycle");
endmodule // sars_monitor

`default_nettype wire

// File: sar_adc_readout_sequencer_test.sv
/*
  Self-checking bench of the readout sequencer.
  Assumes sars_top, sars_adc_model and sars_monitor are compiled.
*/
`timescale 1ns/100ps
`default_nettype none

module sar_adc_readout_sequencer_test;
  import sars_pkg::*;
  logic clk_i, reset_i, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv;
  logic en, smp, conv, pulse, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd_d;
  logic [1:0] br, rr;
  logic [4:0] chan, salt, last_ch;
  logic [9:0] res;
  int error_cnt, checked, cycles, smp_cnt, smp_base, last_smp;

  sars_top dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_r), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd_d),
    .s_axi_rresp_o(rr), .adc_enable_o(en), .adc_chan_o(chan),
    .adc_sample_o(smp), .adc_convert_o(conv), .adc_result_i(res),
    .completion_irq_pulse_o(pulse), .irq_o(irq));
  sars_adc_model adc (.adc_chan_i(chan), .adc_convert_i(conv),
    .salt_i(salt), .adc_result_o(res));

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_i);
      if (!aw_ok && awr === 1'b1)
      begin
        aw_ok = 1'b1;
        awv <= 1'b0;
      end
      if (!w_ok && wr_r === 1'b1)
      begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bv !== 1'b1);
    bry <= 1'b0;
    chk({30'h0, br}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] r);
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk_i); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk_i); while (rv !== 1'b1);
    rry <= 1'b0;
    chk(rd_d, e);
    chk({30'h0, rr}, {30'h0, r});
  endtask
  // Sample cycles are counted since the previous pulse.
  task automatic wait_pulse();
    do @(posedge clk_i); while (pulse !== 1'b1);
    last_ch = chan;
    last_smp = smp_cnt - smp_base;
    smp_base = smp_cnt;
    do @(posedge clk_i); while (pulse === 1'b1);
  endtask
  function automatic logic [31:0] ctrl(input logic [1:0] m,
    input logic c, input logic [4:0] ch);
    return {22'h0, 1'b1, ch, c, m, 1'b1};
  endfunction
  task automatic stop_test();
    $display("Errors %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ******************************************************************
  // Clock, counters and timeout
  // ******************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (smp === 1'b1)
      smp_cnt <= smp_cnt + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial
  begin
    {reset_i, awv, wv, bry, arv, rry} = 6'h20;
    {awa, ara, wd, salt} = '0;
    {error_cnt, checked, cycles, smp_cnt, smp_base} = '0;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(OFF_EN_DLY, {16'h0, EN_DLY_RST}, RESP_OKAY);
    rd(OFF_SMP, {16'h0, SMP_RST}, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'h1, RESP_SLVERR);
    wr(OFF_EN_DLY, 32'h2, RESP_OKAY);
    wr(OFF_SMP, 32'h3, RESP_OKAY);
    wr(OFF_IRQ_MASK, 32'h3, RESP_OKAY);
    wr(OFF_CTRL, {29'h0, MODE_RR, 1'b0}, RESP_OKAY);
    wr(OFF_CTRL, {29'h0, MODE_BAD, 1'b0}, RESP_OKAY);
    rd(OFF_CTRL, {29'h0, MODE_RR, 1'b0}, RESP_OKAY);
    salt <= 5'h15;
    wr(OFF_CTRL, ctrl(MODE_SINGLE, 1'b0, 5'h05), RESP_OKAY);
    wait_pulse();
    chk({27'h0, last_ch}, 32'h5);
    chk(last_smp, 32'h3);
    rd(OFF_SINGLE, {22'h0, 5'h15, 5'h05}, RESP_OKAY);
    rd(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    rd(OFF_STATUS, 32'h250, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h3, RESP_OKAY);
    wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    // Continuous run on channel 7, then a stop request mid-run.
    salt <= 5'h0A;
    wr(OFF_CTRL, ctrl(MODE_SINGLE, 1'b1, 5'h07), RESP_OKAY);
    wait_pulse();
    wait_pulse();
    chk(last_smp, 32'h3);
    chk({27'h0, last_ch}, 32'h7);
    wr(OFF_CTRL, ctrl(MODE_SINGLE, 1'b0, 5'h03), RESP_OKAY);
    wait_pulse();
    chk({27'h0, last_ch}, 32'h7);
    rd(OFF_SINGLE, {22'h0, 5'h0A, 5'h07}, RESP_OKAY);
    repeat (40) @(posedge clk_i);
    chk(smp_cnt - smp_base, 32'h0);
    wr(OFF_IRQ_STAT, 32'h3, RESP_OKAY);
    salt <= 5'h11;
    wr(OFF_CTRL, ctrl(MODE_ONCE, 1'b0, 5'h00), RESP_OKAY);
    for (int i = 0; i < 12; i++)
    begin
      wait_pulse();
      chk({27'h0, last_ch}, i);
    end
    rd(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 12; i++)
      rd(OFF_RES0 + 8'(4 * i), {22'h0, 5'h11, 5'(i)}, RESP_OKAY);
    chk(smp_cnt - smp_base, 32'h0);
    salt <= 5'h0C;
    wr(OFF_CTRL, ctrl(MODE_RR, 1'b0, 5'h00), RESP_OKAY);
    repeat (14) wait_pulse();
    chk({27'h0, last_ch}, 32'h1);
    for (int i = 0; i < 12; i++)
      rd(OFF_RES0 + 8'(4 * i), {22'h0, 5'h0C, 5'(i)}, RESP_OKAY);
    wait_pulse();
    chk({31'h0, en}, 32'h1);
    // Stop the round-robin at a boundary, then disable and restart, so
    // the enable delay must run again before sampling.
    wr(OFF_CTRL, ctrl(MODE_SINGLE, 1'b0, 5'h02), RESP_OKAY);
    wait_pulse();
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    wr(OFF_CTRL, ctrl(MODE_SINGLE, 1'b0, 5'h02), RESP_OKAY);
    rd(OFF_STATUS, 32'h29, RESP_OKAY);
    wait_pulse();
    chk({27'h0, last_ch}, 32'h2);
    chk(last_smp, 32'h3);
    stop_test();
  end
endmodule // sar_adc_readout_sequencer_test

bind sars_top sars_monitor mon (.clk_i, .reset_i, .s_axi_awready_o,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rvalid_o, .adc_enable_o, .adc_chan_o, .adc_sample_o,
  .adc_convert_o, .completion_irq_pulse_o);

`default_nettype wire
